// ---- hdl/dif_map.svh ----
// Purpose: constants for the digital input function logic
// Assumes: 20 MHz ref_clk
// Notes: select codes, times and widths
`ifndef DIF_MAP_SVH
`define DIF_MAP_SVH
`define DIF_CLK_HZ 20000000
`define DIF_SCAN_NS 5000000
`define DIF_SCAN_CYC (`DIF_SCAN_NS / (1000000000 / `DIF_CLK_HZ))
`define DIF_TBASE_MS 100
`define DIF_TBASE_SCANS ((`DIF_TBASE_MS * 1000000) / `DIF_SCAN_NS)
`define DIF_SEL_NULL 7'h00
`define DIF_SEL_EMS 7'h01
`define DIF_SEL_SP3 7'h02
`define DIF_SEL_SP2 7'h03
`define DIF_SEL_SP1 7'h04
`define DIF_SEL_JOG 7'h05
`define DIF_SEL_OH 7'h06
`define DIF_SEL_OFFD 7'h07
`define DIF_SEL_BBH 7'h08
`define DIF_SEL_FJOG 7'h09
`define DIF_SEL_RJOG 7'h0A
`define DIF_SEL_OND 7'h0B
`define DIF_SEL_UDLO 7'h0F
`define DIF_SEL_UDHI 7'h10
`define DIF_SEL_UDHOLD 7'h11
`define DIF_SEL_BBL 7'h12
`define DIF_SEL_UDUP 7'h13
`define DIF_SEL_UDDN 7'h14
`define DIF_SEL_ACLR 7'h15
`define DIF_SEL_SET1 7'h16
`define DIF_SEL_CLR1 7'h17
`define DIF_SEL_SET2 7'h18
`define DIF_SEL_CLR2 7'h19
`define DIF_SEL_SETB 7'h1A
`define DIF_SEL_CLRB 7'h1B
`define DIF_SEL_CLKIN 7'h1C
`define DIF_SEL_STEP0 7'h50
`define DIF_SRC_UD0 8'h06
`define DIF_SRC_UD1 8'h07
`define DIF_SRC_UD2 8'h13
`define DIF_IN_TWO 1
`define DIF_IN_FOUR 3
`define DIF_ADDR_SEL0 12'h000
`define DIF_ADDR_TPER 12'h010
`define DIF_ADDR_CTRL 12'h014
`define DIF_ADDR_STAT 12'h018
`define DIF_ADDR_UDC 12'h01C
`define DIF_ADDR_SPD 12'h020
`define DIF_CTRL_RUN 0
`define DIF_CTRL_ALM 1
`define DIF_TPER_RST 16'h000A
`endif

// ---- hdl/dif_pkg.sv ----
// Purpose: types for the digital input function logic
// Assumes: used as dif_pkg::name
// Notes: none
package dif_pkg;
  typedef enum logic [2:0] {SRC_MAIN, SRC_STEP, SRC_SP3, SRC_SP2, SRC_SP1, SRC_JOG} dif_src_t;
  typedef enum logic [1:0] {BR_IDLE, BR_ACTIVE, BR_DONE} dif_brake_t;
endpackage : dif_pkg

// ---- hdl/dif_logic.sv ----
// Purpose: multi-function digital input decoding for a motor drive
// Assumes: inputs synchronous to ref_clk, APB register access
// Notes: all decoding acts on 5 ms scan samples
`timescale 1ns/1ns
`include "dif_map.svh"

// Summary of operation
// R1: emergency input while running gives timed DC brake
// R2: speed priority jog, sp1, sp2, sp3, step, normal
// R3: codes 5,4,3 decode; jog rate both ways
// R4: presets use their own accel/decel rates
// R5: jog/presets need run command unless forced
// R6: overheat code 6 blocks transistors, raises alarm
// R7: counter mode only with code 28 on input two/four
// R8: timer mode ticks every 0.1 s
// R9: off-delay output on at once, off after period
// R10: on-delay output on after input held period
// R11: external clock input no faster than 1000/s; edges found from 5 ms scan samples count at most 100/s
// R12: one shared timer/counter for all delay types
// R13: counter advances on each off-to-on clock edge
// R14: code 28 counts only from input two
// R15: active-high base block stops drive, then search
// R16: active-low base block stops drive, then search
// R17: codes 9/10 force forward/reverse jog run
// R18: codes 15/16/17 load low, load high, hold
// R19: up/down controls meaningful for source 6/7/19
// R20: codes 19/20 ramp counter at main rates
// R21: alarm clear resets only with alarm present
// R22: two latches, set/clear codes 22-27, shared codes
// R23: set pulse latches, clear pulse releases
// R24: inputs sampled every 5.0 ms
// R25: open input reads off, common-tied reads on
// R26: per-input select; code 0 forces off
// R27: clear beats set in same scan
module dif_logic #(
  parameter int NUM_IN = 4,
  parameter int SCAN_CYC = `DIF_SCAN_CYC,
  parameter int TBASE_SCANS = `DIF_TBASE_SCANS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NUM_IN-1:0] inputClosed,
  input wire logic runCmd,
  input wire logic alarmIn,
  input wire logic [15:0] mainSpeed,
  input wire logic [15:0] jogSpeed,
  input wire logic [15:0] spd1Speed,
  input wire logic [15:0] spd2Speed,
  input wire logic [15:0] spd3Speed,
  input wire logic [15:0] mainAccelRate,
  input wire logic [15:0] mainDecelRate,
  input wire logic [15:0] jogRampRate,
  input wire logic [15:0] spd1AccelRate,
  input wire logic [15:0] spd1DecelRate,
  input wire logic [15:0] spd2AccelRate,
  input wire logic [15:0] spd2DecelRate,
  input wire logic [15:0] spd3AccelRate,
  input wire logic [15:0] spd3DecelRate,
  input wire logic [15:0] dcBrakeLevelSetting,
  input wire logic [15:0] dcBrakeDurationSetting,
  input wire logic [15:0] updownUpperLimit,
  input wire logic [15:0] updownLowerLimit,
  input wire logic [7:0] speedSourceSetting,
  input wire logic udRampTick,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic dcBrakeOn,
  output logic [15:0] dcBrakeLevel,
  output logic [15:0] speedRequest,
  output logic [15:0] accelRate,
  output logic [15:0] decelRate,
  output logic runActive,
  output logic jogForward,
  output logic jogReverse,
  output logic baseBlock,
  output logic speedSearch,
  output logic overheatAlarm,
  output logic alarmClear,
  output logic offDelayOutput,
  output logic onDelayOutput,
  output logic [1:0] latchQ,
  output logic [1:0] latchQn
);
  logic [6:0] selReg_r [NUM_IN];
  logic [15:0] timerPeriod_r;
  logic [1:0] ctrl_r;
  logic [$clog2(SCAN_CYC)-1:0] scanCnt_r;
  logic scanTick;
  logic [NUM_IN-1:0] sample_r;
  logic [NUM_IN-1:0] prevSample_r;
  logic [NUM_IN-1:0] useSample;
  logic fnEms, fnSp1, fnSp2, fnSp3, fnJog, fnOh, fnOffd, fnOnd, fnBbh, fnBbl;
  logic fnFjog, fnRjog, fnUdLo, fnUdHi, fnUdHold, fnUdUp, fnUdDn, fnAclr;
  logic fnSet1, fnClr1, fnSet2, fnClr2, fnSetB, fnClrB;
  logic [3:0] stepBits;
  logic counterMode, clkEdge;
  logic [15:0] tcCount_r;
  logic [$clog2(TBASE_SCANS)-1:0] tbCnt_r;
  logic tbTick;
  logic offdPrev_r;
  dif_pkg::dif_brake_t brake_r;
  logic [15:0] brakeCnt_r;
  logic [15:0] udCount_r;
  logic udActive;
  logic bbPrev_r;
  dif_pkg::dif_src_t src;
  logic anyRun;
  logic [15:0] stepSpeed;

  initial begin
    // the register map holds exactly four selects; scan check needs three cycles
    if (NUM_IN != 4 || SCAN_CYC < 3 || TBASE_SCANS < 2) $error("dif_logic: unsupported parameters");
  end

  // scan divider: one pulse per 5 ms
  always_ff @(posedge ref_clk) begin
    if (rst || scanTick) scanCnt_r <= '0;
    else scanCnt_r <= scanCnt_r + 1'b1;
  end
  assign scanTick = (scanCnt_r == ($clog2(SCAN_CYC))'(SCAN_CYC - 1)); // R24

  // sample inputs; closed to common reads on
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sample_r <= '0;
      prevSample_r <= '0;
    end else if (scanTick) begin
      sample_r <= inputClosed; // R24 R25
      prevSample_r <= sample_r;
    end
  end

  // function decode: an input is on for a code only when selected to it
  always_comb begin
    {fnEms, fnSp1, fnSp2, fnSp3, fnJog, fnOh, fnOffd, fnOnd, fnBbh, fnBbl} = '0;
    {fnFjog, fnRjog, fnUdLo, fnUdHi, fnUdHold, fnUdUp, fnUdDn, fnAclr} = '0;
    {fnSet1, fnClr1, fnSet2, fnClr2, fnSetB, fnClrB} = '0;
    stepBits = '0;
    clkEdge = 1'b0;
    counterMode = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      useSample[i] = sample_r[i] && (selReg_r[i] != `DIF_SEL_NULL); // R26
      case (selReg_r[i])
        `DIF_SEL_EMS: fnEms |= useSample[i];
        `DIF_SEL_SP1: fnSp1 |= useSample[i]; // R3
        `DIF_SEL_SP2: fnSp2 |= useSample[i]; // R3
        `DIF_SEL_SP3: fnSp3 |= useSample[i];
        `DIF_SEL_JOG: fnJog |= useSample[i]; // R3
        `DIF_SEL_OH: fnOh |= useSample[i];
        `DIF_SEL_OFFD: fnOffd |= useSample[i];
        `DIF_SEL_OND: fnOnd |= useSample[i];
        `DIF_SEL_BBH: fnBbh |= useSample[i];
        `DIF_SEL_BBL: fnBbl |= !sample_r[i]; // R16
        `DIF_SEL_FJOG: fnFjog |= useSample[i];
        `DIF_SEL_RJOG: fnRjog |= useSample[i];
        `DIF_SEL_UDLO: fnUdLo |= useSample[i];
        `DIF_SEL_UDHI: fnUdHi |= useSample[i];
        `DIF_SEL_UDHOLD: fnUdHold |= useSample[i];
        `DIF_SEL_UDUP: fnUdUp |= useSample[i];
        `DIF_SEL_UDDN: fnUdDn |= useSample[i];
        `DIF_SEL_ACLR: fnAclr |= useSample[i];
        `DIF_SEL_SET1: fnSet1 |= useSample[i]; // R22
        `DIF_SEL_CLR1: fnClr1 |= useSample[i];
        `DIF_SEL_SET2: fnSet2 |= useSample[i];
        `DIF_SEL_CLR2: fnClr2 |= useSample[i];
        `DIF_SEL_SETB: fnSetB |= useSample[i];
        `DIF_SEL_CLRB: fnClrB |= useSample[i];
        `DIF_SEL_CLKIN: begin
          // only input two feeds the counter; input four switches mode
          if (i == `DIF_IN_TWO || i == `DIF_IN_FOUR) counterMode = 1'b1; // R7
          if (i == `DIF_IN_TWO) clkEdge = scanTick && sample_r[i] && !prevSample_r[i]; // R13 R14
        end
        default: begin
          if (selReg_r[i] >= `DIF_SEL_STEP0 && selReg_r[i] < `DIF_SEL_STEP0 + 7'h04) begin
            stepBits[selReg_r[i][1:0]] = stepBits[selReg_r[i][1:0]] | useSample[i];
          end
        end
      endcase
    end
  end

  // speed priority and ramp rate choice
  always_comb begin
    anyRun = runCmd || fnFjog || fnRjog; // R5 R17
    src = dif_pkg::SRC_MAIN;
    if (fnJog || fnFjog || fnRjog) src = dif_pkg::SRC_JOG; // R2
    else if (fnSp1) src = dif_pkg::SRC_SP1;
    else if (fnSp2) src = dif_pkg::SRC_SP2;
    else if (fnSp3) src = dif_pkg::SRC_SP3;
    else if (stepBits != 4'h0) src = dif_pkg::SRC_STEP;
    stepSpeed = (stepBits[3] ? spd3Speed : 16'h0000) + (stepBits[2] ? spd2Speed : 16'h0000)
      + (stepBits[1] ? spd1Speed : 16'h0000) + (stepBits[0] ? jogSpeed : 16'h0000);
  end

  // registered speed request and rates
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      speedRequest <= 16'h0000;
      accelRate <= 16'h0000;
      decelRate <= 16'h0000;
      runActive <= 1'b0;
      jogForward <= 1'b0;
      jogReverse <= 1'b0;
    end else begin
      runActive <= anyRun && !baseBlock;
      jogForward <= fnFjog; // R17
      jogReverse <= fnRjog && !fnFjog;
      case (src)
        dif_pkg::SRC_JOG: begin
          speedRequest <= jogSpeed;
          accelRate <= jogRampRate; // R3
          decelRate <= jogRampRate;
        end
        dif_pkg::SRC_SP1: begin
          speedRequest <= spd1Speed; // R4
          accelRate <= spd1AccelRate;
          decelRate <= spd1DecelRate;
        end
        dif_pkg::SRC_SP2: begin
          speedRequest <= spd2Speed; // R4
          accelRate <= spd2AccelRate;
          decelRate <= spd2DecelRate;
        end
        dif_pkg::SRC_SP3: begin
          speedRequest <= spd3Speed; // R4
          accelRate <= spd3AccelRate;
          decelRate <= spd3DecelRate;
        end
        dif_pkg::SRC_STEP: begin
          speedRequest <= stepSpeed;
          accelRate <= mainAccelRate;
          decelRate <= mainDecelRate;
        end
        default: begin
          speedRequest <= udActive ? udCount_r : mainSpeed; // R19
          accelRate <= mainAccelRate;
          decelRate <= mainDecelRate;
        end
      endcase
    end
  end

  // up/down counter; active only for the counter speed sources
  assign udActive = (speedSourceSetting == `DIF_SRC_UD0) || (speedSourceSetting == `DIF_SRC_UD1)
    || (speedSourceSetting == `DIF_SRC_UD2); // R19
  always_ff @(posedge ref_clk) begin
    if (rst) udCount_r <= 16'h0000;
    else if (udActive) begin
      if (fnUdLo) udCount_r <= updownLowerLimit; // R18
      else if (fnUdHi) udCount_r <= updownUpperLimit; // R18
      else if (fnUdHold) udCount_r <= udCount_r; // R18
      else if (udRampTick && fnUdUp && udCount_r < updownUpperLimit) begin
        // ramp tick is paced by the main accel rate outside this block
        // one extra bit so a large step cannot wrap past the limit
        udCount_r <= ({1'b0, udCount_r} + {1'b0, mainAccelRate} > {1'b0, updownUpperLimit}) ? updownUpperLimit
          : 16'(udCount_r + mainAccelRate); // R20
      end else if (udRampTick && fnUdDn && udCount_r > updownLowerLimit) begin
        udCount_r <= ({1'b0, udCount_r} < {1'b0, updownLowerLimit} + {1'b0, mainDecelRate}) ? updownLowerLimit
          : 16'(udCount_r - mainDecelRate); // R20
      end
    end
  end

  // emergency dc brake sequence, counted in scans
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      brake_r <= dif_pkg::BR_IDLE;
      brakeCnt_r <= 16'h0000;
    end else begin
      case (brake_r)
        dif_pkg::BR_IDLE: if (fnEms && runActive) begin
          brake_r <= dif_pkg::BR_ACTIVE; // R1
          brakeCnt_r <= 16'h0000;
        end
        dif_pkg::BR_ACTIVE: if (scanTick) begin
          if (brakeCnt_r + 16'h0001 >= dcBrakeDurationSetting) brake_r <= dif_pkg::BR_DONE; // R1
          brakeCnt_r <= brakeCnt_r + 16'h0001;
        end
        dif_pkg::BR_DONE: if (!fnEms) brake_r <= dif_pkg::BR_IDLE;
        default: brake_r <= dif_pkg::BR_IDLE;
      endcase
    end
  end
  assign dcBrakeOn = (brake_r == dif_pkg::BR_ACTIVE);
  assign dcBrakeLevel = dcBrakeOn ? dcBrakeLevelSetting : 16'h0000;

  // base block, overheat and speed search
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      baseBlock <= 1'b0;
      bbPrev_r <= 1'b0;
      speedSearch <= 1'b0;
      overheatAlarm <= 1'b0;
      alarmClear <= 1'b0;
    end else begin
      baseBlock <= fnBbh || fnBbl || fnOh; // R6 R15 R16
      bbPrev_r <= fnBbh || fnBbl;
      speedSearch <= bbPrev_r && !(fnBbh || fnBbl); // R15 R16
      // alarm clear only acts while an alarm stands
      alarmClear <= fnAclr && (alarmIn || overheatAlarm || ctrl_r[`DIF_CTRL_ALM]); // R21
      if (fnOh) overheatAlarm <= 1'b1; // R6
      else if (alarmClear) overheatAlarm <= 1'b0;
    end
  end

  // time base for timer mode: 20 scans make 0.1 s
  always_ff @(posedge ref_clk) begin
    if (rst || counterMode) tbCnt_r <= '0;
    else if (scanTick) tbCnt_r <= (tbCnt_r == ($clog2(TBASE_SCANS))'(TBASE_SCANS - 1)) ? '0 : tbCnt_r + 1'b1;
  end
  assign tbTick = scanTick && !counterMode && (tbCnt_r == ($clog2(TBASE_SCANS))'(TBASE_SCANS - 1)); // R8

  // single shared timer/counter; off-delay takes it before on-delay
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tcCount_r <= 16'h0000;
      offDelayOutput <= 1'b0;
      onDelayOutput <= 1'b0;
      offdPrev_r <= 1'b0;
    end else begin
      offdPrev_r <= fnOffd;
      if (fnOffd) begin
        offDelayOutput <= 1'b1; // R9
        tcCount_r <= 16'h0000;
      end else if (offDelayOutput) begin
        if (tcCount_r >= timerPeriod_r) offDelayOutput <= 1'b0; // R9
        else if (counterMode ? clkEdge : tbTick) tcCount_r <= tcCount_r + 16'h0001; // R12
      end else if (!fnOnd) begin
        onDelayOutput <= 1'b0; // R10
        tcCount_r <= 16'h0000;
      end else if (tcCount_r >= timerPeriod_r) begin
        onDelayOutput <= 1'b1; // R10
      end else if (counterMode ? clkEdge : tbTick) begin
        tcCount_r <= tcCount_r + 16'h0001; // R7 R12 R13
      end
    end
  end

  // two latches with true and complement outputs
  for (genvar k = 0; k < 2; k++) begin : g_latch
    logic setIn, clrIn;
    assign setIn = (k == 0 ? fnSet1 : fnSet2) || fnSetB; // R22
    assign clrIn = (k == 0 ? fnClr1 : fnClr2) || fnClrB; // R22
    always_ff @(posedge ref_clk) begin
      if (rst) latchQ[k] <= 1'b0;
      else if (clrIn) latchQ[k] <= 1'b0; // R23 R27
      else if (setIn) latchQ[k] <= 1'b1; // R23
    end
    assign latchQn[k] = !latchQ[k];
    latch_clear_a: assert property (@(posedge ref_clk) disable iff (rst) clrIn |=> !latchQ[k]) // R27
      else $error("latch not cleared");
  end

  // apb slave: zero wait states, unmapped addresses error
  assign pready = 1'b1;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_IN; i++) selReg_r[i] <= `DIF_SEL_NULL;
      timerPeriod_r <= `DIF_TPER_RST;
      ctrl_r <= 2'h0;
    end else if (psel && penable && pwrite) begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (paddr == `DIF_ADDR_SEL0 + 12'(4 * i)) selReg_r[i] <= pwdata[6:0]; // R26
      end
      if (paddr == `DIF_ADDR_TPER) timerPeriod_r <= pwdata[15:0];
      if (paddr == `DIF_ADDR_CTRL) ctrl_r <= pwdata[1:0];
    end
  end
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr < `DIF_ADDR_SEL0 + 12'(4 * NUM_IN) && paddr[1:0] == 2'h0) prdata = {25'h0, selReg_r[paddr[3:2]]};
    else if (paddr == `DIF_ADDR_TPER) prdata = {16'h0, timerPeriod_r};
    else if (paddr == `DIF_ADDR_CTRL) prdata = {30'h0, ctrl_r};
    else if (paddr == `DIF_ADDR_STAT) begin
      prdata = {19'h0, counterMode, speedSearch, baseBlock, overheatAlarm, dcBrakeOn,
        offDelayOutput, onDelayOutput, latchQ, sample_r[3:0]};
    end else if (paddr == `DIF_ADDR_UDC) prdata = {16'h0, udCount_r};
    else if (paddr == `DIF_ADDR_SPD) prdata = {16'h0, speedRequest};
    else pslverr = psel && penable;
    if (!(psel && penable)) prdata = 32'h0000_0000;
  end

  // checks
  scan_period_a: assert property (@(posedge ref_clk) disable iff (rst) // R24
    scanTick |=> !scanTick [*2]) else $error("scan tick too frequent");
  offd_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // R9
    fnOffd |=> offDelayOutput) else $error("off-delay output not on");
  ond_low_a: assert property (@(posedge ref_clk) disable iff (rst) // R10
    (!fnOnd && !fnOffd && !offDelayOutput) |=> !onDelayOutput) else $error("on-delay output not off");
  overheat_block_a: assert property (@(posedge ref_clk) disable iff (rst) // R6
    fnOh |=> baseBlock && overheatAlarm) else $error("overheat not blocking");
  base_block_a: assert property (@(posedge ref_clk) disable iff (rst) // R15
    (fnBbh || fnBbl) |=> baseBlock) else $error("base block missing");
  jog_rate_a: assert property (@(posedge ref_clk) disable iff (rst) // R3
    fnJog |=> accelRate == $past(jogRampRate) && decelRate == $past(jogRampRate)) else $error("jog rate wrong");
  brake_start_a: assert property (@(posedge ref_clk) disable iff (rst) // R1
    (brake_r == dif_pkg::BR_IDLE && fnEms && runActive) |=> dcBrakeOn) else $error("dc brake not started");
  alarm_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // R21
    alarmClear |-> $past(fnAclr)) else $error("alarm clear without input");
  no_count_a: assert property (@(posedge ref_clk) disable iff (rst) // R7
    counterMode |-> !tbTick) else $error("time base in counter mode");
endmodule : dif_logic

// ---- test/dif_switch_model.sv ----
// Purpose: contact model on the digital input terminals
// Assumes: contact state commanded by the bench
// Notes: no bounce; contacts move just after a clock edge
`timescale 1ns/1ns
module dif_switch_model #(
  parameter int NUM_IN = 4
) (
  input wire logic ref_clk,
  input wire logic [NUM_IN-1:0] contactOn,
  output logic [NUM_IN-1:0] inputClosed
);
  // start open so the design never sees an unknown terminal
  initial inputClosed = '0;
  // open contact reads off, contact tied to common reads on
  always @(posedge ref_clk) begin
    // the bench moves a contact at most once per scan, slow enough for the scan to sample every change
    inputClosed <= contactOn;
  end
endmodule : dif_switch_model

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the digital input function logic
// Assumes: shortened scan and time base, zero-wait APB slave
// Notes: drivers queue expectations, a monitor process compares them
`timescale 1ns/1ns
`include "dif_map.svh"
`define CMP(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
  localparam int SCAN = 20;
  localparam int TBS = 4;
  localparam int TICK = SCAN * TBS;
  typedef struct {int sel; logic [31:0] val;} dif_note_t;
  dif_note_t q[$];
  int failures = 0;
  int checked = 0;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] contactOn = '0;
  logic [3:0] inputClosed;
  logic runCmd = 1'b0;
  logic alarmIn = 1'b0;
  logic udRampTick = 1'b0;
  logic [7:0] speedSourceSetting = 8'h00;
  logic [15:0] st [0:17];
  logic [11:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = '0, prdata, rdData;
  logic pready, pslverr, rdErr, ssSeen;
  logic dcBrakeOn, runActive, jogForward, jogReverse, baseBlock, speedSearch;
  logic overheatAlarm, alarmClear, offDelayOutput, onDelayOutput;
  logic [15:0] dcBrakeLevel, speedRequest, accelRate, decelRate;
  logic [1:0] latchQ, latchQn;
  int ix [0:3] = '{1, 2, 3, 4};
  int ia [0:3] = '{7, 8, 10, 12};
  int id [0:3] = '{7, 9, 11, 13};

  always #25 ref_clk = ~ref_clk;

  dif_switch_model #(.NUM_IN(4)) u_sw (.ref_clk(ref_clk), .contactOn(contactOn), .inputClosed(inputClosed));

  dif_logic #(.NUM_IN(4), .SCAN_CYC(SCAN), .TBASE_SCANS(TBS)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .inputClosed(inputClosed), .runCmd(runCmd), .alarmIn(alarmIn),
    .mainSpeed(st[0]), .jogSpeed(st[1]), .spd1Speed(st[2]), .spd2Speed(st[3]), .spd3Speed(st[4]),
    .mainAccelRate(st[5]), .mainDecelRate(st[6]), .jogRampRate(st[7]), .spd1AccelRate(st[8]),
    .spd1DecelRate(st[9]), .spd2AccelRate(st[10]), .spd2DecelRate(st[11]), .spd3AccelRate(st[12]),
    .spd3DecelRate(st[13]), .dcBrakeLevelSetting(st[14]), .dcBrakeDurationSetting(st[15]),
    .updownUpperLimit(st[16]), .updownLowerLimit(st[17]), .speedSourceSetting(speedSourceSetting),
    .udRampTick(udRampTick), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dcBrakeOn(dcBrakeOn),
    .dcBrakeLevel(dcBrakeLevel), .speedRequest(speedRequest), .accelRate(accelRate),
    .decelRate(decelRate), .runActive(runActive), .jogForward(jogForward), .jogReverse(jogReverse),
    .baseBlock(baseBlock), .speedSearch(speedSearch), .overheatAlarm(overheatAlarm),
    .alarmClear(alarmClear), .offDelayOutput(offDelayOutput), .onDelayOutput(onDelayOutput),
    .latchQ(latchQ), .latchQn(latchQn));

  // the search pulse lasts one cycle, so a sticky flag keeps it for the monitor
  always @(posedge ref_clk) if (speedSearch === 1'b1) ssSeen <= 1'b1;

  function automatic logic [31:0] obsOf(int s);
    case (s)
      0: return rdData;
      1: return {31'h0, rdErr};
      2: return {30'h0, latchQ};
      3: return {30'h0, latchQn};
      4: return {31'h0, overheatAlarm};
      5: return {16'h0, speedRequest};
      6: return {16'h0, accelRate};
      7: return {16'h0, decelRate};
      8: return {31'h0, jogForward};
      9: return {31'h0, runActive};
      10: return {31'h0, offDelayOutput};
      11: return {31'h0, onDelayOutput};
      12: return {31'h0, baseBlock};
      13: return {31'h0, ssSeen};
      14: return {31'h0, dcBrakeOn};
      15: return {16'h0, dcBrakeLevel};
      16: return {31'h0, alarmClear};
      17: return {31'h0, jogReverse};
      default: return {31'h0, rdData[12]};
    endcase
  endfunction : obsOf

  // monitor: oldest note against what the outputs show now
  initial begin
    dif_note_t nt;
    forever begin
      wait (q.size() != 0);
      nt = q.pop_front();
      `CMP(obsOf(nt.sel), nt.val)
    end
  end

  task automatic note(input int s, input logic [31:0] v);
    q.push_back('{s, v});
    #0;
  endtask : note

  task automatic wrap_up();
    wait (q.size() == 0);
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin failures++; wrap_up(); end
  endtask : apb

  task automatic pick(input int i, input logic [6:0] c);
    apb(1'b1, 12'(`DIF_ADDR_SEL0 + 4 * i), {25'h0, c});
  endtask : pick

  // a change is decoded within one scan plus two cycles
  task automatic setIn(input logic [3:0] v);
    @(posedge ref_clk);
    contactOn <= v;
    repeat (SCAN + 3) @(posedge ref_clk);
    #1;
  endtask : setIn

  task automatic waitVal(input int s, input logic [31:0] v, input int maxc);
    int c;
    c = 0;
    while (obsOf(s) !== v && c < maxc) begin @(posedge ref_clk); #1; c++; end
    if (c >= maxc) begin failures++; wrap_up(); end
  endtask : waitVal

  initial begin
    #4000000;
    failures++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h9fcbfae9));
    foreach (st[i]) st[i] = 16'($urandom());
    st[2][15] = ~st[1][15];
    st[3][14] = ~st[2][14];
    st[4][13] = ~st[3][13];
    st[15] = 16'h0003;
    ssSeen = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    note(3, 32'h3);
    note(4, 32'h0);
    pick(0, `DIF_SEL_SET1);
    apb(1'b0, `DIF_ADDR_SEL0, 32'h0);
    note(0, 32'h16);
    apb(1'b0, 12'h0FC, 32'h0);
    note(1, 32'h1);
    apb(1'b1, `DIF_ADDR_TPER, 32'h3);
    pick(1, `DIF_SEL_CLR1); pick(2, `DIF_SEL_SETB); pick(3, `DIF_SEL_CLRB);
    setIn(4'b0001); note(2, 32'h1);
    setIn(4'b0000); note(2, 32'h1);
    setIn(4'b0011); note(2, 32'h0);
    setIn(4'b0100); note(2, 32'h3);
    setIn(4'b1000); note(2, 32'h0); note(3, 32'h3);
    pick(0, `DIF_SEL_NULL); pick(1, `DIF_SEL_ACLR); pick(2, `DIF_SEL_NULL); pick(3, `DIF_SEL_NULL);
    setIn(4'b0110); note(16, 32'h0); note(2, 32'h0);
    setIn(4'b0000);
    pick(0, `DIF_SEL_OH);
    setIn(4'b0001); note(4, 32'h1);
    setIn(4'b0000); note(4, 32'h1);
    setIn(4'b0010); note(4, 32'h0);
    setIn(4'b0000);
    runCmd <= 1'b1;
    pick(0, `DIF_SEL_JOG); pick(1, `DIF_SEL_SP1); pick(2, `DIF_SEL_SP2); pick(3, `DIF_SEL_SP3);
    for (int k = 0; k < 4; k++) begin
      setIn(4'hF << k);
      note(5, {16'h0, st[ix[k]]});
      note(6, {16'h0, st[ia[k]]});
      note(7, {16'h0, st[id[k]]});
    end
    runCmd <= 1'b0;
    setIn(4'b0001); note(9, 32'h0); note(8, 32'h0);
    pick(0, `DIF_SEL_FJOG); pick(1, `DIF_SEL_RJOG);
    setIn(4'b0000);
    setIn(4'b0001); note(8, 32'h1);
    setIn(4'b0010); note(17, 32'h1);
    setIn(4'b0000);
    runCmd <= 1'b1;
    pick(0, `DIF_SEL_EMS);
    setIn(4'b0001); note(14, 32'h1); note(15, {16'h0, st[14]});
    waitVal(14, 32'h0, 3 * SCAN + 5); note(15, 32'h0);
    setIn(4'b0000);
    runCmd <= 1'b0;
    pick(0, `DIF_SEL_NULL); pick(1, `DIF_SEL_NULL); pick(2, `DIF_SEL_OFFD);
    setIn(4'b0100); note(10, 32'h1);
    setIn(4'b0000); repeat (TICK) @(posedge ref_clk); #1;
    note(10, 32'h1);
    waitVal(10, 32'h0, 3 * TICK + SCAN); note(10, 32'h0);
    pick(2, `DIF_SEL_OND);
    setIn(4'b0100); repeat (TICK) @(posedge ref_clk); #1;
    note(11, 32'h0);
    waitVal(11, 32'h1, 3 * TICK + SCAN); note(11, 32'h1);
    setIn(4'b0000); note(11, 32'h0);
    pick(2, `DIF_SEL_NULL); pick(3, `DIF_SEL_BBH);
    setIn(4'b1000); note(12, 32'h1); ssSeen = 1'b0;
    setIn(4'b0000); note(12, 32'h0); note(13, 32'h1);
    pick(3, `DIF_SEL_NULL); pick(1, `DIF_SEL_CLKIN);
    apb(1'b0, `DIF_ADDR_STAT, 32'h0); note(18, 32'h1);
    pick(2, `DIF_SEL_OND);
    setIn(4'b0100);
    for (int k = 0; k < 3; k++) begin
      note(11, 32'h0);
      setIn(4'b0110);
      setIn(4'b0100);
    end
    waitVal(11, 32'h1, 2 * SCAN); note(11, 32'h1);
    setIn(4'b0000);
    pick(1, `DIF_SEL_NULL); pick(2, `DIF_SEL_CLKIN);
    apb(1'b0, `DIF_ADDR_STAT, 32'h0); note(18, 32'h0);
    wrap_up();
  end
endmodule : tb_top
